/* rtl/frm_fault_mgr.v */
// Purpose: Fault and warning response manager of a power converter controller
// Assumes: All inputs synchronous to hclk; temperature in degrees C, unsigned
// Notes: Overvoltage latch-off clears only through reset or a thermal fault
// Notes: A status read clears every bit; a set in that cycle is kept
// Notes: Overcurrent events are counted once per switching cycle enable
// Notes: Summary of operation follows
// Summary of operation
// RULE1 - Programmable overtemperature fault, latch or restart: both switches off, power good low.
// RULE2 - Ignored overtemperature or low-side overcurrent fault: PWM keeps control, power good high.
// RULE3 - Overtemperature warning never stops switching; power good follows fault response.
// RULE4 - Bandgap overtemperature always shuts both switches off, restarts after cooling.
// RULE5 - Overcurrent fault with latch: both switches off after three counts, stay off.
// RULE6 - Overcurrent fault with restart: off after three counts, restart after seven rise times.
// RULE7 - Ignored high-side overcurrent: each high-side pulse ends at peak limit.
// RULE8 - Low-side overcurrent warning keeps switching; power good follows fault response.
// RULE9 - Overvoltage fault: high side off, low side latched on or until feedback low.
// RULE10 - Overvoltage restart waits seven rise times; power good low during fault.
// RULE11 - All events monitored always, raise alert, each one maskable. The overvoltage warning has no status bit and raises no alert.
// RULE12 - Host programs identical responses into both paralleled converters.
// RULE13 - Overcurrent counter counts up per event cycle, down otherwise, trips at three.
// RULE14 - Overtemperature restart only after temperature falls twenty degrees below trip.
// RULE15 - Each fault class keeps its own response, applied at next evaluation.
`timescale 1ns/100ps
`include "frm_map.vh"

module frm_fault_mgr #(
	parameter PWM_DIV = `FRM_PWM_DIV,
	parameter TON_RISE_CYC = `FRM_TON_RISE_CYC
) (
	input wire hclk, // System clock
	input wire hresetn, // Async reset, active low
	input wire hsel, // Slave select
	input wire [11:0] haddr, // Byte address
	input wire [1:0] htrans, // Transfer type
	input wire hwrite, // Write access
	input wire [2:0] hsize, // Transfer size
	input wire [31:0] hwdata, // Write data
	input wire hready, // Bus ready
	output reg [31:0] hrdata, // Read data
	output reg hreadyout, // Slave ready
	output reg hresp, // Response, always OKAY
	input wire pwm_hs_in, // PWM demand, high side
	input wire pwm_ls_in, // PWM demand, low side
	input wire [7:0] temp_in, // Junction temperature
	input wire [7:0] iout_in, // Averaged low-side current
	input wire hs_oc_in, // High-side peak limit exceeded
	input wire ov_in, // Feedback above overvoltage level
	input wire ov_warn_in, // Feedback above overvoltage warning
	input wire feedback_sense_input, // Feedback below 0.2 V
	output reg hs_gate_out, // High-side switch drive
	output reg ls_gate_out, // Low-side switch drive
	output reg power_good_out, // Power good
	output reg alert_n_out, // Alert line, active low
	output reg irq_out, // Interrupt, active high
	output reg [3:0] output_voltage_limit_percent_select // Limit selection
);

	localparam ST_RUN = 5'b00001;
	localparam ST_OFF = 5'b00010;
	localparam ST_COOL = 5'b00100;
	localparam ST_DIS = 5'b01000;
	localparam ST_WAIT = 5'b10000;
	localparam [31:0] WAIT_CYC = `FRM_HICCUP_MULT * TON_RISE_CYC;

	function ignored;
		input [1:0] rsp;
		begin
			ignored = rsp[1];
		end
	endfunction

	function [7:0] cool_level;
		input [7:0] trip;
		begin
			cool_level = (trip > `FRM_HYST_C) ? trip - `FRM_HYST_C : 8'h00;
		end
	endfunction

	reg [7:0] ot_fault_q;
	reg [7:0] ot_warn_q;
	reg [7:0] oc_fault_q;
	reg [7:0] oc_warn_q;
	reg [7:0] limsel_q;
	reg [7:0] resp_q;
	reg [6:0] status_q;
	reg [6:0] mask_q;
	reg en_q;
	reg [4:0] state_q;
	reg [7:0] cool_trip_q;
	reg [31:0] div_q;
	reg [31:0] wait_q;
	reg cyc_en_q;
	reg [1:0] oc_cnt_q;
	reg ls_ev_q;
	reg hs_ev_q;
	reg hs_lim_q;
	reg dis_done_q;
	reg rsp_latch_q;
	reg wr_pend_q;
	reg [7:0] wr_idx_q;

	wire acc = hsel & hready & htrans[1];
	wire [7:0] idx = haddr[9:2];
	// Upper address words are reserved: reads give zero, writes drop
	wire in_map = (haddr[11:10] == 2'b00);
	wire rd_status = acc & ~hwrite & (idx == `FRM_IDX_STATUS) & in_map;

	// Live condition detection, monitored in every state
	wire otf = temp_in >= ot_fault_q; // see RULE11
	wire otw = temp_in >= ot_warn_q;
	wire bgot = temp_in >= `FRM_BG_TSD_C;
	wire lsocw = iout_in >= oc_warn_q;
	wire lsoc = iout_in >= oc_fault_q;
	wire [1:0] rsp_ot = resp_q[`FRM_RSP_OT]; // see RULE15
	wire [1:0] rsp_ls = resp_q[`FRM_RSP_LSOC];
	wire [1:0] rsp_hs = resp_q[`FRM_RSP_HSOC];
	wire [1:0] rsp_ov = resp_q[`FRM_RSP_OV];
	wire ev_now = ls_ev_q | hs_ev_q | lsoc | hs_oc_in;
	wire oc_trip = cyc_en_q & ev_now & (oc_cnt_q == `FRM_OC_TRIP - 2'd1); // see RULE13
	wire oc_from_ls = ls_ev_q | lsoc;
	wire [1:0] rsp_oc = oc_from_ls ? rsp_ls : rsp_hs;
	wire hsocf = oc_trip & ~oc_from_ls;
	wire lsocf = oc_trip & oc_from_ls;
	wire wait_done = (wait_q >= WAIT_CYC - 1) & cyc_en_q;
	wire fb_low = feedback_sense_input;

	// Sticky status; a set in the clearing read cycle is kept
	wire [6:0] st_set = {ov_in, hsocf, lsocw, lsocf, bgot, otw, otf}; // see RULE11
	wire [6:0] st_d = (status_q & ~({7{rd_status}})) | st_set;

	// Register bus
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_q <= 1'b0;
			wr_idx_q <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_q <= acc & hwrite & in_map;
			wr_idx_q <= idx;
			if (acc & ~hwrite) begin
				if (!in_map)
					hrdata <= 32'h00000000;
				else if (idx == `FRM_IDX_OT_FAULT)
					hrdata <= {24'h000000, ot_fault_q};
				else if (idx == `FRM_IDX_OT_WARN)
					hrdata <= {24'h000000, ot_warn_q};
				else if (idx == `FRM_IDX_OC_FAULT)
					hrdata <= {24'h000000, oc_fault_q};
				else if (idx == `FRM_IDX_OC_WARN)
					hrdata <= {24'h000000, oc_warn_q};
				else if (idx == `FRM_IDX_LIMSEL)
					hrdata <= {24'h000000, limsel_q};
				else if (idx == `FRM_IDX_RESP)
					hrdata <= {24'h000000, resp_q};
				else if (idx == `FRM_IDX_STATUS)
					hrdata <= {25'h0000000, status_q};
				else if (idx == `FRM_IDX_MASK)
					hrdata <= {25'h0000000, mask_q};
				else if (idx == `FRM_IDX_STATE)
					hrdata <= {22'h000000, oc_cnt_q, power_good_out, ls_gate_out, hs_gate_out, state_q};
				else if (idx == `FRM_IDX_CTRL)
					hrdata <= {31'h00000000, en_q};
				else
					hrdata <= 32'h00000000;
			end
		end
	end

	// Register file, written in the data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ot_fault_q <= `FRM_RST_OT_FAULT;
			ot_warn_q <= `FRM_RST_OT_WARN;
			oc_fault_q <= `FRM_RST_OC_FAULT;
			oc_warn_q <= `FRM_RST_OC_WARN;
			limsel_q <= `FRM_RST_LIMSEL;
			resp_q <= `FRM_RST_RESP;
			mask_q <= `FRM_RST_MASK;
			en_q <= `FRM_RST_CTRL;
			status_q <= 7'h00;
		end else begin
			status_q <= st_d;
			// Status, state and unmapped words ignore writes
			if (wr_pend_q) begin
				if (wr_idx_q == `FRM_IDX_OT_FAULT)
					ot_fault_q <= hwdata[7:0];
				else if (wr_idx_q == `FRM_IDX_OT_WARN)
					ot_warn_q <= hwdata[7:0];
				else if (wr_idx_q == `FRM_IDX_OC_FAULT)
					oc_fault_q <= hwdata[7:0];
				else if (wr_idx_q == `FRM_IDX_OC_WARN)
					oc_warn_q <= hwdata[7:0];
				else if (wr_idx_q == `FRM_IDX_LIMSEL)
					limsel_q <= hwdata[7:0];
				else if (wr_idx_q == `FRM_IDX_RESP)
					resp_q <= hwdata[7:0];
				else if (wr_idx_q == `FRM_IDX_MASK)
					mask_q <= hwdata[6:0];
				else if (wr_idx_q == `FRM_IDX_CTRL)
					en_q <= hwdata[0];
			end
		end
	end

	// Switching cycle enable and overcurrent counter
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q <= 32'h00000000;
			cyc_en_q <= 1'b0;
			oc_cnt_q <= 2'd0;
			ls_ev_q <= 1'b0;
			hs_ev_q <= 1'b0;
			hs_lim_q <= 1'b0;
		end else begin
			cyc_en_q <= (div_q == PWM_DIV - 2);
			div_q <= (div_q >= PWM_DIV - 1) ? 32'h00000000 : div_q + 32'h00000001;
			if (cyc_en_q) begin
				ls_ev_q <= 1'b0;
				hs_ev_q <= 1'b0;
				hs_lim_q <= 1'b0;
				// Cleared outside RUN so each restart counts afresh
				if (state_q != ST_RUN)
					oc_cnt_q <= 2'd0;
				else if (ev_now) // see RULE13
					oc_cnt_q <= (oc_cnt_q == `FRM_OC_TRIP) ? oc_cnt_q : oc_cnt_q + 2'd1;
				else if (oc_cnt_q != 2'd0)
					oc_cnt_q <= oc_cnt_q - 2'd1;
			end else begin
				ls_ev_q <= ls_ev_q | lsoc;
				hs_ev_q <= hs_ev_q | hs_oc_in;
				// Peak limit ends the pulse for the rest of the cycle
				hs_lim_q <= hs_lim_q | hs_oc_in; // see RULE7
			end
		end
	end

	// Fault response state machine
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_RUN;
			cool_trip_q <= 8'h00;
			wait_q <= 32'h00000000;
			dis_done_q <= 1'b0;
			rsp_latch_q <= 1'b0;
		end else begin
			case (state_q)
			ST_RUN: begin
				wait_q <= 32'h00000000;
				dis_done_q <= 1'b0;
				if (bgot) begin
					state_q <= ST_COOL; // see RULE4
					cool_trip_q <= `FRM_BG_TSD_C;
				end else if (otf & ~ignored(rsp_ot)) begin
					state_q <= (rsp_ot == `FRM_RSP_LATCH) ? ST_OFF : ST_COOL; // see RULE1
					cool_trip_q <= ot_fault_q;
				end else if (ov_in & ~ignored(rsp_ov)) begin
					state_q <= ST_DIS; // see RULE9
					rsp_latch_q <= (rsp_ov == `FRM_RSP_LATCH);
				end else if (oc_trip & ~ignored(rsp_oc)) begin
					// Third counted cycle done, switches go off now
					state_q <= (rsp_oc == `FRM_RSP_LATCH) ? ST_OFF : ST_WAIT; // see RULE5 see RULE6
				end
			end
			ST_OFF: begin
				// Latched until software drops the enable
				if (!en_q)
					state_q <= ST_RUN;
			end
			ST_COOL: begin
				// Bandgap and programmable trips share this wait, each with its own level
				if (temp_in <= cool_level(cool_trip_q))
					state_q <= ST_RUN; // see RULE14
			end
			ST_DIS: begin
				// Low side per select bit; only restart mode counts toward restart
				if (fb_low)
					dis_done_q <= 1'b1;
				if (!rsp_latch_q) begin
					if (cyc_en_q)
						wait_q <= wait_q + 32'h00000001;
					if (wait_done)
						state_q <= ST_RUN; // see RULE10
				end
			end
			ST_WAIT: begin
				// Both switches stay off while the hiccup timer runs
				if (cyc_en_q)
					wait_q <= wait_q + 32'h00000001;
				if (wait_done)
					state_q <= ST_RUN; // see RULE6
			end
			default: state_q <= ST_OFF;
			endcase
			// Thermal faults also end a discharge or hiccup wait, and an
			// overvoltage during the wait discharges before restarting
			if ((state_q == ST_DIS) | (state_q == ST_WAIT)) begin
				if (bgot) begin
					state_q <= ST_COOL; // see RULE4
					cool_trip_q <= `FRM_BG_TSD_C;
				end else if (otf & ~ignored(rsp_ot)) begin
					state_q <= (rsp_ot == `FRM_RSP_LATCH) ? ST_OFF : ST_COOL; // see RULE1
					cool_trip_q <= ot_fault_q;
				end else if ((state_q == ST_WAIT) & ov_in & ~ignored(rsp_ov)) begin
					state_q <= ST_DIS; // see RULE9
					rsp_latch_q <= (rsp_ov == `FRM_RSP_LATCH);
					wait_q <= 32'h00000000;
				end
			end
		end
	end

	// Outputs, all from flip-flops
	wire run = (state_q == ST_RUN) & en_q;
	wire ls_dis = (state_q == ST_DIS) & ~(limsel_q[`FRM_LIM_OVSEL] & dis_done_q); // see RULE9
	wire pg_warn = (otw & ~ignored(rsp_ot)) | (lsocw & ~ignored(rsp_ls)); // see RULE3 see RULE8
	// Overvoltage warning pulls power good low in every mode
	wire pg_d = run & ~pg_warn & ~(ov_in & ~ignored(rsp_ov)) & ~ov_warn_in; // see RULE2 see RULE10
	wire irq_d = |(st_d & ~mask_q); // see RULE11

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hs_gate_out <= 1'b0;
			ls_gate_out <= 1'b0;
			power_good_out <= 1'b0;
			alert_n_out <= 1'b1;
			irq_out <= 1'b0;
			output_voltage_limit_percent_select <= 4'h0;
		end else begin
			// Warnings and ignored faults never block the PWM path, except the high-side peak limit, which cuts the pulse in every response mode
			hs_gate_out <= run & pwm_hs_in & ~hs_lim_q & ~hs_oc_in; // see RULE2 see RULE7
			ls_gate_out <= (run & pwm_ls_in) | ls_dis; // see RULE8
			power_good_out <= pg_d;
			irq_out <= irq_d;
			alert_n_out <= ~irq_d;
			output_voltage_limit_percent_select <= limsel_q[`FRM_LIM_PCT];
		end
	end

endmodule // frm_fault_mgr

/* rtl/frm_map.vh */
// Purpose: Constants of the fault response manager
// Assumes: Word-aligned AHB-Lite register map, byte address = index * 4
// Notes: Definitions only
`ifndef FRM_MAP_VH
`define FRM_MAP_VH
// Register indexes
`define FRM_IDX_OC_FAULT 8'h46
`define FRM_IDX_OC_WARN 8'h4a
`define FRM_IDX_OT_FAULT 8'h4f
`define FRM_IDX_OT_WARN 8'h51
`define FRM_IDX_LIMSEL 8'hd7
`define FRM_IDX_RESP 8'he0
`define FRM_IDX_STATUS 8'he1
`define FRM_IDX_MASK 8'he2
`define FRM_IDX_STATE 8'he3
`define FRM_IDX_CTRL 8'he4
// Reset values
`define FRM_RST_OT_FAULT 8'h7d
`define FRM_RST_OT_WARN 8'h64
`define FRM_RST_OC_FAULT 8'hff
`define FRM_RST_OC_WARN 8'hf0
`define FRM_RST_LIMSEL 8'h00
`define FRM_RST_RESP 8'h55
`define FRM_RST_MASK 7'h00
`define FRM_RST_CTRL 1'b0
// Response encodings, two bits each
`define FRM_RSP_LATCH 2'b00
`define FRM_RSP_RESTART 2'b01
`define FRM_RSP_IGNORE 2'b10
// Response field positions
`define FRM_RSP_OT 1:0
`define FRM_RSP_LSOC 3:2
`define FRM_RSP_HSOC 5:4
`define FRM_RSP_OV 7:6
// Limit select fields
`define FRM_LIM_OVSEL 7
`define FRM_LIM_PCT 3:0
// Status bit positions
`define FRM_ST_OTF 0
`define FRM_ST_OTW 1
`define FRM_ST_BGOT 2
`define FRM_ST_LSOCF 3
`define FRM_ST_LSOCW 4
`define FRM_ST_HSOCF 5
`define FRM_ST_OVF 6
// Fixed thresholds and counts
`define FRM_BG_TSD_C 8'd145
`define FRM_HYST_C 8'd20
`define FRM_OC_TRIP 2'd3
`define FRM_HICCUP_MULT 7
`define FRM_PWM_DIV 200
`define FRM_TON_RISE_CYC 1000
`endif

/* testbench/frm_assertions.sv */
// Purpose: Port checks of the fault manager
// Assumes: Outputs lag their cause by up to two clocks
// Notes: Bound in the bench top
`timescale 1ns/100ps
module frm_assertions (
	input wire hclk, // Clock
	input wire hresetn, // Reset
	input wire hreadyout, // Ready
	input wire hresp, // Response
	input wire pwm_hs_in, // Demand
	input wire [7:0] temp_in, // Temperature
	input wire hs_oc_in, // Peak limit
	input wire hs_gate_out, // High drive
	input wire ls_gate_out, // Low drive
	input wire power_good_out, // Good
	input wire alert_n_out, // Alert
	input wire irq_out // Interrupt
);
	reg hot_q;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Die too hot until it cools to the hysteresis point
	always @(posedge hclk or negedge hresetn)
		if (!hresetn) hot_q <= 1'b0;
		else if (temp_in >= 8'd150) hot_q <= 1'b1;
		else if (temp_in <= 8'd125) hot_q <= 1'b0;
	sequence oc_held;
		hs_oc_in [*3];
	endsequence
	alert_inv_a: assert property (alert_n_out == !irq_out) else $error("alert bad");
	hs_pwm_a: assert property (hs_gate_out |-> $past(pwm_hs_in) || $past(pwm_hs_in, 2))
		else $error("high side without demand");
	hs_peak_a: assert property ($rose(hs_oc_in) |-> ##[1:2] !hs_gate_out) else $error("no cut");
	oc_cut_a: assert property (oc_held |-> !hs_gate_out) else $error("pulse not cut");
	bg_off_a: assert property (temp_in >= 8'd150 |-> ##2 !hs_gate_out && !ls_gate_out && !power_good_out)
		else $error("hot but on");
	bg_cool_a: assert property (hot_q && $past(hot_q, 2) |-> !hs_gate_out && !ls_gate_out)
		else $error("on before cooled");
	pg_temp_a: assert property (power_good_out |-> $past(temp_in, 2) < 8'd150) else $error("good while hot");
	bus_ok_a: assert property (hreadyout && !hresp) else $error("bus not ready");
endmodule // frm_assertions

/* testbench/frm_host.sv */
// Purpose: Bus host that programs the fault manager
// Assumes: Single word transfers
// Notes: A stalled bus ends the run
`timescale 1ns/100ps
module frm_host (
	input wire hclk, // Clock
	input wire hready, // Ready
	input wire [31:0] hrdata, // Read data
	output logic hsel, // Select
	output logic [11:0] haddr, // Address
	output logic [1:0] htrans, // Type
	output logic hwrite, // Write
	output logic [2:0] hsize, // Size
	output logic [31:0] hwdata // Write data
);
	initial begin
		hsel = 1'b0;
		haddr = 12'h000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
	end
	// One response image serves both units of a parallel pair
	task automatic xfer(input logic [7:0] idx, input logic w, input logic [31:0] wd, output logic [31:0] rv);
		int n;
		hsel <= 1'b1;
		haddr <= {2'b00, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		for (int p = 0; p < 2; p++) begin
			n = 0;
			do begin
				@(posedge hclk);
				n++;
			end while (!hready && n < 20);
			if (!hready)
				fault_response_manager_tb_top.complete_run(1'b1);
			if (p == 0) begin
				hsel <= 1'b0;
				htrans <= 2'b00;
				hwdata <= wd;
			end
		end
		rv = hrdata;
	endtask
endmodule // frm_host

/* testbench/fault_response_manager_tb_top.sv */
// Purpose: Self-checking bench of the fault manager
// Assumes: Shortened counts, PWM_DIV 8 and TON_RISE_CYC 2
// Notes: Overcurrent pulses sit one switching cycle apart
`timescale 1ns/100ps
module fault_response_manager_tb_top;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pwm_hs_in, pwm_ls_in, hs_oc_in, ov_in, ov_warn_in;
	logic feedback_sense_input, hs_gate_out, ls_gate_out, power_good_out, alert_n_out, irq_out;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] output_voltage_limit_percent_select;
	logic [7:0] temp_in, iout_in;
	logic [11:0] haddr;
	logic [31:0] hwdata, hrdata, rv;
	logic [7:0] ri [10] = '{8'h4f, 8'h51, 8'h46, 8'h4a, 8'hd7, 8'he0, 8'he1, 8'he2, 8'he4, 8'he8};
	logic [7:0] rr [10] = '{8'h7d, 8'h64, 8'hff, 8'hf0, 8'h00, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00};
	int mismatches = 0;
	int num_checks = 0;
	frm_fault_mgr #(.PWM_DIV(8), .TON_RISE_CYC(2)) frm_fault_mgr_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pwm_hs_in, .pwm_ls_in, .temp_in,
		.iout_in, .hs_oc_in, .ov_in, .ov_warn_in, .feedback_sense_input, .hs_gate_out, .ls_gate_out, .power_good_out,
		.alert_n_out, .irq_out, .output_voltage_limit_percent_select);
	frm_host frm_host_inst (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	task automatic complete_run(input bit tmo);
		if (tmo) mismatches++;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		frm_host_inst.xfer(i, 1'b1, d, rv);
	endtask
	task automatic rd(input logic [7:0] i, input logic [31:0] e);
		frm_host_inst.xfer(i, 1'b0, 32'h0, rv);
		chk($sformatf("reg %h", i), e, rv);
	endtask
	// Sample on the falling edge so the rising edge's updates have landed
	task automatic gates(input int n, input logic [2:0] e);
		cyc(n);
		@(negedge hclk);
		chk("hs ls pg", e, {hs_gate_out, ls_gate_out, power_good_out});
		@(posedge hclk);
	endtask
	// Wide enough to trip the pulse cut, short enough for one cycle
	task automatic ocp(input int n);
		repeat (n) begin
			hs_oc_in <= 1'b1;
			cyc(3);
			hs_oc_in <= 1'b0;
			cyc(5);
		end
	endtask
	initial begin
		hresetn = 1'b0;
		{pwm_hs_in, pwm_ls_in, hs_oc_in, ov_in, ov_warn_in, feedback_sense_input} = 6'b110000;
		temp_in = 8'd25;
		iout_in = 8'h00;
		cyc(2);
		hresetn <= 1'b1;
		foreach (ri[k]) rd(ri[k], rr[k]);
		wr(8'he4, 32'h1);
		gates(3, 3'b111);
		temp_in <= 8'd110;
		gates(3, 3'b110);
		chk("irq", 1, irq_out);
		rd(8'he1, 32'h2);
		wr(8'he2, 32'h2);
		cyc(3);
		chk("irq", 0, irq_out);
		wr(8'he0, 32'h56);
		gates(3, 3'b111);
		temp_in <= 8'd130;
		gates(3, 3'b111);
		wr(8'he0, 32'h55);
		gates(3, 3'b000);
		temp_in <= 8'd110;
		gates(4, 3'b000);
		temp_in <= 8'd90;
		gates(4, 3'b111);
		wr(8'he0, 32'h56);
		temp_in <= 8'd150;
		gates(3, 3'b000);
		temp_in <= 8'd130;
		gates(4, 3'b000);
		temp_in <= 8'd120;
		gates(4, 3'b111);
		temp_in <= 8'd25;
		wr(8'he0, 32'h46);
		ocp(2);
		cyc(8);
		ocp(1);
		gates(0, 3'b111);
		ocp(1);
		gates(3, 3'b000);
		gates(40, 3'b000);
		wr(8'he4, 32'h0);
		wr(8'he4, 32'h1);
		wr(8'he0, 32'h56);
		cyc(30);
		ocp(3);
		gates(3, 3'b000);
		gates(70, 3'b000);
		gates(60, 3'b111);
		wr(8'h46, 32'h80);
		wr(8'h4a, 32'h40);
		iout_in <= 8'h60;
		gates(4, 3'b110);
		wr(8'he0, 32'h5a);
		iout_in <= 8'h90;
		gates(40, 3'b111);
		iout_in <= 8'h00;
		rd(8'he1, 32'h3f);
		wr(8'he0, 32'h6a);
		hs_oc_in <= 1'b1;
		gates(1, 3'b011);
		hs_oc_in <= 1'b0;
		gates(2, 3'b011);
		gates(20, 3'b111);
		ov_warn_in <= 1'b1;
		gates(3, 3'b110);
		ov_warn_in <= 1'b0;
		gates(3, 3'b111);
		wr(8'hd7, 32'h85);
		cyc(2);
		chk("limsel", 4'h5, output_voltage_limit_percent_select);
		ov_in <= 1'b1;
		cyc(2);
		ov_in <= 1'b0;
		gates(3, 3'b010);
		chk("irq", 1, irq_out);
		rd(8'he1, 32'h40);
		chk("irq", 0, irq_out);
		feedback_sense_input <= 1'b1;
		gates(3, 3'b000);
		gates(130, 3'b111);
		feedback_sense_input <= 1'b0;
		wr(8'hd7, 32'h0);
		wr(8'he0, 32'h1a);
		ov_in <= 1'b1;
		cyc(2);
		ov_in <= 1'b0;
		gates(3, 3'b010);
		feedback_sense_input <= 1'b1;
		gates(150, 3'b010);
		complete_run(1'b0);
	end
endmodule // fault_response_manager_tb_top
bind frm_fault_mgr frm_assertions frm_assertions_inst (.hclk, .hresetn, .hreadyout, .hresp, .pwm_hs_in, .temp_in,
	.hs_oc_in, .hs_gate_out, .ls_gate_out, .power_good_out, .alert_n_out, .irq_out);
